// File: power_failure_carry_flag.sv
/*
 * Power-failure detector: timer carry flag, its carry disable flip-flop,
 * the watchdog/stack reset flag, an interrupt status/mask pair and the
 * APB slave that reaches them.
 * Assumes all inputs are synchronous to pclk; presetn is the power-on
 * reset; por_clear and reset_pin_req are synchronous levels.
 */
// Implementation choices: the register addresses and register access over APB.
// What this block does
// - power-on-clear sets the carry disable flip-flop
// - reading the carry flag clears the disable flip-flop
// - disable flip-flop set blocks carry pulses from setting the flag
// - after power-on-clear the carry flag starts cleared
// - with disable clear, each carry pulse rising edge sets the flag
// - reading the carry flag clears it
// - flag reads 0 after power-on, 1 after chip-enable restart
// - reset pin acts on flag and disable flip-flop like power-on
// - watchdog or stack reset sets a read-and-clear flag at 16H bit 0
module power_failure_carry_flag (
   input  wire logic        pclk,             // system clock
   input  wire logic        presetn,          // async reset, active low
   input  wire logic [11:0] paddr,            // APB byte address
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB enable
   input  wire logic        pwrite,           // APB direction
   input  wire logic [31:0] pwdata,           // APB write data
   input  wire logic [3:0]  pstrb,            // APB byte strobes
   output logic      [31:0] prdata,           // APB read data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB error
   input  wire logic        por_clear,        // voltage detector output
   input  wire logic        reset_pin_req,    // external reset pin active
   input  wire logic        carry_pulse,      // timer 0 carry setting pulse
   input  wire logic        wdt_reset_evt,    // watchdog reset pulse
   input  wire logic        stack_reset_evt,  // stack over/underflow pulse
   output logic             carry_disable,    // disable flip-flop state
   output logic             irq               // level interrupt
);
   logic [31:0]                 prdata_ff;
   logic                        pready_ff;
   logic                        pslverr_ff;
   logic                        dis_ff;
   logic [pfd_pkg::IRQ_N-1:0]   mask_ff;
   logic                        irq_ff;
   logic [31:0]                 nxt_rdata;
   logic                        nxt_hit;
   logic [pfd_pkg::IDX_W-1:0]   idx;
   logic                        setup;
   logic                        rd_setup;
   logic                        wr_done;
   logic                        carry_rd;
   logic                        wdt_rd;
   logic                        por_any;
   logic [1:0]                  rises;
   logic                        carry_rise;
   logic                        por_rise;
   logic [pfd_pkg::IRQ_N-1:0]   irq_evt;
   logic [pfd_pkg::IRQ_N-1:0]   irq_stat;

   flag_if carry_fi ();
   flag_if wdt_fi ();
   flag_if irq_fi [pfd_pkg::IRQ_N] ();

   assign idx      = paddr[11:2];
   assign setup    = psel & ~penable;
   assign rd_setup = setup & ~pwrite;
   assign wr_done  = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   assign por_any  = por_clear | reset_pin_req;

   // side effects of a read happen at the setup edge with the data capture
   assign carry_rd = rd_setup & (paddr[1:0] == 2'h0)
                   & (idx == pfd_pkg::CARRY_IDX);
   assign wdt_rd   = rd_setup & (paddr[1:0] == 2'h0)
                   & (idx == pfd_pkg::WDT_IDX);

   rise_detect #(
      .W (2)
   ) u_rise (
      .clk   (pclk),
      .rst_n (presetn),
      .lvl   ({por_any, carry_pulse}),
      .rise  (rises)
   );

   assign carry_rise = rises[0];
   assign por_rise   = rises[1];

   // carry disable flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dis_ff <= pfd_pkg::DIS_RST;
      end else if (por_any) begin
         dis_ff <= 1'b1;
      end else if (carry_rd) begin
         dis_ff <= 1'b0;
      end
   end

   // timer carry flag: zero at power-on, kept across chip-enable restart
   assign carry_fi.init = por_any;
   assign carry_fi.set  = carry_rise & ~dis_ff;
   assign carry_fi.clr  = carry_rd;

   sticky_flag #(
      .RST_VAL (pfd_pkg::FLAG_RST)
   ) u_carry (
      .clk   (pclk),
      .rst_n (presetn),
      .f     (carry_fi)
   );

   // watchdog or stack reset flag, read-and-clear
   assign wdt_fi.init = por_any;
   assign wdt_fi.set  = wdt_reset_evt | stack_reset_evt;
   assign wdt_fi.clr  = wdt_rd;

   sticky_flag #(
      .RST_VAL (pfd_pkg::FLAG_RST)
   ) u_wdt (
      .clk   (pclk),
      .rst_n (presetn),
      .f     (wdt_fi)
   );

   // interrupt status, write one to clear
   assign irq_evt[pfd_pkg::IRQ_CARRY_BIT] = carry_fi.set;
   assign irq_evt[pfd_pkg::IRQ_POR_BIT]   = por_rise;
   assign irq_evt[pfd_pkg::IRQ_WDT_BIT]   = wdt_fi.set;

   for (genvar i = 0; i < pfd_pkg::IRQ_N; i++) begin : g_irq
      assign irq_fi[i].init = 1'b0;
      assign irq_fi[i].set  = irq_evt[i];
      assign irq_fi[i].clr  = wr_done & pstrb[0] & pwdata[i]
                            & (idx == pfd_pkg::IRQ_STAT_IDX);
      assign irq_stat[i]    = irq_fi[i].value;

      sticky_flag #(
         .RST_VAL (1'b0)
      ) u_flag (
         .clk   (pclk),
         .rst_n (presetn),
         .f     (irq_fi[i])
      );
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= pfd_pkg::MASK_RST;
      end else if (wr_done && pstrb[0] &&
                   idx == pfd_pkg::IRQ_MASK_IDX) begin
         mask_ff <= pwdata[pfd_pkg::IRQ_N-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_stat & mask_ff);
      end
   end

   // read mux and address decode
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_hit   = (paddr[1:0] == 2'h0);
      case (idx)
         pfd_pkg::CARRY_IDX: begin
            nxt_rdata[0] = carry_fi.value;
         end
         pfd_pkg::STATE_IDX: begin
            nxt_rdata[pfd_pkg::ST_CARRY_BIT] = carry_fi.value;
            nxt_rdata[pfd_pkg::ST_DIS_BIT]   = dis_ff;
            nxt_rdata[pfd_pkg::ST_WDT_BIT]   = wdt_fi.value;
            nxt_rdata[pfd_pkg::ST_POR_BIT]   = por_any;
         end
         pfd_pkg::IRQ_STAT_IDX: begin
            nxt_rdata[pfd_pkg::IRQ_N-1:0] = irq_stat;
         end
         pfd_pkg::IRQ_MASK_IDX: begin
            nxt_rdata[pfd_pkg::IRQ_N-1:0] = mask_ff;
         end
         pfd_pkg::WDT_IDX: begin
            nxt_rdata[0] = wdt_fi.value;
         end
         default: begin
            nxt_hit = 1'b0;
         end
      endcase
   end

   // apb response: one access cycle, ready in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup & ~nxt_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_ff <= nxt_hit ? nxt_rdata : 32'h0000_0000;
      end
   end

   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign carry_disable = dis_ff;
   assign irq           = irq_ff;
endmodule

// File: pfd_pkg.sv
/*
 * Constants shared by the power-failure carry-flag block: register word
 * indices, field positions, reset values and widths.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package pfd_pkg;
   localparam int         ADDR_W         = 12;
   localparam int         DATA_W         = 32;
   localparam int         IDX_W          = 10;

   // word indices; the byte address is four times the index
   localparam logic [9:0] CARRY_IDX      = 10'h000;
   localparam logic [9:0] STATE_IDX      = 10'h001;
   localparam logic [9:0] IRQ_STAT_IDX   = 10'h002;
   localparam logic [9:0] IRQ_MASK_IDX   = 10'h003;
   localparam logic [9:0] WDT_IDX        = 10'h016;

   // state register fields
   localparam int         ST_CARRY_BIT   = 0;
   localparam int         ST_DIS_BIT     = 1;
   localparam int         ST_WDT_BIT     = 2;
   localparam int         ST_POR_BIT     = 3;

   // interrupt status and mask fields
   localparam int         IRQ_CARRY_BIT  = 0;
   localparam int         IRQ_POR_BIT    = 1;
   localparam int         IRQ_WDT_BIT    = 2;
   localparam int         IRQ_N          = 3;

   localparam logic       DIS_RST        = 1'b1;
   localparam logic       FLAG_RST       = 1'b0;
   localparam logic [2:0] MASK_RST       = 3'h0;
endpackage

// File: flag_if.sv
/*
 * Control and value of one sticky flag.
 * Assumes the owner module holds the flip-flop and the user drives it.
 */
interface flag_if;
   logic init;   // force to zero, strongest
   logic set;    // hardware event
   logic clr;    // read or write-one clear
   logic value;  // current flag

   modport owner (input init, input set, input clr, output value);
   modport user  (output init, output set, output clr, input value);
endinterface

// File: sticky_flag.sv
/*
 * One sticky flag: init beats set, set beats clear.
 * Assumes init, set and clr are synchronous to clk.
 */
module sticky_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk,    // system clock
   input wire logic rst_n,  // async reset, active low
   flag_if.owner    f       // flag controls
);
   logic flag_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= RST_VAL;
      end else if (f.init) begin
         flag_ff <= 1'b0;
      end else if (f.set) begin
         flag_ff <= 1'b1;
      end else if (f.clr) begin
         flag_ff <= 1'b0;
      end
   end

   assign f.value = flag_ff;
endmodule

// File: rise_detect.sv
/*
 * Rising-edge detector for a group of synchronous levels.
 * Assumes inputs already belong to the clk domain.
 */
module rise_detect #(
   parameter int W = 1
) (
   input  wire logic         clk,    // system clock
   input  wire logic         rst_n,  // async reset, active low
   input  wire logic [W-1:0] lvl,    // levels to watch
   output logic      [W-1:0] rise    // one-cycle pulse per rising edge
);
   logic [W-1:0] prev_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= lvl;
      end
   end

   assign rise = lvl & ~prev_ff;
endmodule

// File: pfc_monitor.sv
/* Port assertions for the power-failure carry-flag block.
   Assumes a bind onto power_failure_carry_flag. */
module pfc_monitor (
   input wire logic        pclk,           // clock
   input wire logic        presetn,        // reset, low
   input wire logic [11:0] paddr,          // address
   input wire logic        psel,           // select
   input wire logic        penable,        // enable
   input wire logic        pwrite,         // direction
   input wire logic [31:0] prdata,         // read data
   input wire logic        pready,         // ready
   input wire logic        pslverr,        // error
   input wire logic        por_clear,      // detector
   input wire logic        reset_pin_req,  // reset pin
   input wire logic        carry_disable,  // disable ff
   input wire logic        irq             // interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_carry;
   logic por_any;
   logic mapped;
   assign rd_carry = psel && !penable && !pwrite && paddr == 12'h000;
   assign por_any  = por_clear | reset_pin_req;
   assign mapped   = paddr[1:0] == 2'h0 && paddr[11:2] inside
      {pfd_pkg::CARRY_IDX, pfd_pkg::STATE_IDX, pfd_pkg::IRQ_STAT_IDX,
       pfd_pkg::IRQ_MASK_IDX, pfd_pkg::WDT_IDX};
   a_por_sets: assert property (por_clear |=> carry_disable)
      else $error("disable not set by detector");
   a_pin_sets: assert property (reset_pin_req |=> carry_disable)
      else $error("disable not set by reset pin");
   a_read_clears: assert property (rd_carry && !por_any
      |=> !carry_disable) else $error("disable not cleared by read");
   a_fall_cause: assert property ($fell(carry_disable)
      |-> $past(rd_carry)) else $error("disable cleared without read");
   a_rise_cause: assert property ($rose(carry_disable)
      |-> $past(por_any)) else $error("disable set without cause");
   a_read_zero: assert property (rd_carry && carry_disable
      |=> prdata[0] == 1'b0) else $error("flag set while disabled");
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_err_map: assert property (pready |-> pslverr == !mapped)
      else $error("error flag wrong for address");
   cover property (rd_carry ##2 prdata[0]);
   cover property (pready && pslverr);
   cover property ($rose(irq));
endmodule

bind power_failure_carry_flag pfc_monitor u_mon (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .por_clear(por_clear), .reset_pin_req(reset_pin_req),
   .carry_disable(carry_disable), .irq(irq));

// File: carry_timer.sv
/* Basic timer model: one carry setting pulse per request.
   Assumes fire is a one-cycle request on clk. */
module carry_timer #(
   parameter int HIGH_CYC = 2
) (
   input  wire logic clk,          // system clock
   input  wire logic rst_n,        // reset, active low
   input  wire logic fire,         // start a pulse
   output logic      carry_pulse   // carry setting pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_ff;
   // held high several cycles: only the rise may count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 0;
      end else if (fire) begin
         cnt_ff <= HIGH_CYC;
      end else if (cnt_ff > 0) begin
         cnt_ff <= cnt_ff - 1;
      end
   end
   assign carry_pulse = cnt_ff > 0; // high for HIGH_CYC cycles after each fire
endmodule

// File: power_failure_carry_flag_tb_top.sv
/* Testbench for the carry-flag block, driven over APB.
   Assumes pfc_monitor and carry_timer are compiled alongside. */
module power_failure_carry_flag_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        por_clear, reset_pin_req, wdt_reset_evt, stack_reset_evt;
   logic        fire, carry_pulse, carry_disable, irq, err;
   logic [11:0] paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, rdat;
   int          num_errors, total_checks;

   power_failure_carry_flag uut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .por_clear(por_clear),
      .reset_pin_req(reset_pin_req), .carry_pulse(carry_pulse),
      .wdt_reset_evt(wdt_reset_evt), .stack_reset_evt(stack_reset_evt),
      .carry_disable(carry_disable), .irq(irq));
   carry_timer u_tmr (.clk(pclk), .rst_n(presetn), .fire(fire),
      .carry_pulse(carry_pulse));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [31:0] e,
                     input string nm);
      apb(1'b0, idx, 32'h0);
      chk(nm, e, rdat);
      chk(nm, 32'h0, {31'h0, err});
   endtask
   task automatic strobe(input int which);
      case (which)
         0: fire <= 1'b1;
         1: wdt_reset_evt <= 1'b1;
         2: stack_reset_evt <= 1'b1;
         3: por_clear <= 1'b1;
         default: reset_pin_req <= 1'b1;
      endcase
      @(posedge pclk);
      {fire, wdt_reset_evt, stack_reset_evt, por_clear, reset_pin_req} <= 5'h00;
      repeat (6) @(posedge pclk);
   endtask
   task automatic finish_test;
      if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      num_errors++;
      finish_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hF;
      {fire, wdt_reset_evt, stack_reset_evt, por_clear, reset_pin_req} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(pfd_pkg::STATE_IDX, 32'h2, "state at reset");
      strobe(0);
      rd(pfd_pkg::STATE_IDX, 32'h2, "state blocked");
      rd(pfd_pkg::IRQ_STAT_IDX, 32'h0, "status blocked");
      rd(pfd_pkg::CARRY_IDX, 32'h0, "carry power-on");
      chk("disable", 32'h0, {31'h0, carry_disable});
      apb(1'b1, pfd_pkg::IRQ_MASK_IDX, 32'h7);
      strobe(0);
      rd(pfd_pkg::STATE_IDX, 32'h1, "state carry set");
      chk("irq raised", 32'h1, {31'h0, irq});
      rd(pfd_pkg::CARRY_IDX, 32'h1, "carry restart");
      rd(pfd_pkg::CARRY_IDX, 32'h0, "carry consumed");
      apb(1'b1, pfd_pkg::IRQ_STAT_IDX, 32'h1);
      rd(pfd_pkg::IRQ_STAT_IDX, 32'h0, "status cleared");
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, pfd_pkg::IRQ_MASK_IDX, 32'h0);
      strobe(0);
      rd(pfd_pkg::IRQ_STAT_IDX, 32'h1, "status masked");
      chk("irq masked", 32'h0, {31'h0, irq});
      pstrb <= 4'h0;
      apb(1'b1, pfd_pkg::IRQ_MASK_IDX, 32'h7);
      pstrb <= 4'hF;
      rd(pfd_pkg::IRQ_MASK_IDX, 32'h0, "mask strobe off");
      chk("irq strobe off", 32'h0, {31'h0, irq});
      for (int i = 3; i < 5; i++) begin
         if (i == 4) strobe(0);
         strobe(i);
         rd(pfd_pkg::STATE_IDX, 32'h2, "state after source");
         rd(pfd_pkg::CARRY_IDX, 32'h0, "carry after source");
      end
      for (int i = 1; i < 3; i++) begin
         strobe(i);
         rd(pfd_pkg::WDT_IDX, 32'h1, "wdt flag");
         rd(pfd_pkg::WDT_IDX, 32'h0, "wdt consumed");
      end
      rd(pfd_pkg::IRQ_STAT_IDX, 32'h7, "status all");
      reset_pin_req <= 1'b1;
      @(posedge pclk);
      rd(pfd_pkg::STATE_IDX, 32'hA, "state pin held");
      rd(pfd_pkg::CARRY_IDX, 32'h0, "carry pin held");
      chk("disable held", 32'h1, {31'h0, carry_disable});
      reset_pin_req <= 1'b0;
      apb(1'b0, 10'h005, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rdat);
      finish_test();
   end
endmodule
